// [design/bst_tap.sv]
`timescale 1ns/10ps
module bst_tap #(
    parameter int NPIN = 8
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic [NPIN-1:0] pin_in_in,
    input wire logic [NPIN-1:0] core_out_in,
    input wire logic [NPIN-1:0] core_oe_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    output logic [NPIN-1:0] pin_out_out,
    output logic [NPIN-1:0] pin_oe_out,
    output logic [NPIN-1:0] core_in_out
);
    localparam int BSW = 3 * NPIN;

    typedef struct packed {
        logic [bst_pkg::SYNC_W-1:0] tck_s;
        logic [bst_pkg::SYNC_W-1:0] tms_s;
        logic [bst_pkg::SYNC_W-1:0] tdi_s;
        logic tck_lvl;
        logic tms_lvl;
        logic tdi_lvl;
        logic [bst_pkg::IR_W-1:0] ir_sh;
        logic [bst_pkg::IR_W-1:0] ir;
        logic [BSW-1:0] dr_sh;
        logic [BSW-1:0] upd;
        logic [bst_pkg::ID_W-1:0] id_sh;
        logic byp;
        logic tdo;
        logic tdo_oe;
        logic [NPIN-1:0] pin_out;
        logic [NPIN-1:0] pin_oe;
        logic [NPIN-1:0] core_in;
    } bst_tap_state_t;

    bst_tap_state_t q;
    bst_tap_state_t d;
    bst_tap_if tap ();
    logic rise;
    logic fall;
    logic shifting;

    function automatic logic uses_chain(input logic [2:0] c);
        uses_chain = (c == bst_pkg::IR_EXTEST) || (c == bst_pkg::IR_SAMPLE);
    endfunction

    function automatic logic drives_chain(input logic [2:0] c);
        drives_chain = (c == bst_pkg::IR_EXTEST) || (c == bst_pkg::IR_CLAMP);
    endfunction

    bst_fsm u_fsm (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .tap(tap)
    );

    // ----------------------------------------
    // pin sampling and clock edge finding
    // ----------------------------------------
    always_comb begin
        rise = (q.tck_s[2] == q.tck_s[1]) && q.tck_s[2] && !q.tck_lvl;
        fall = (q.tck_s[2] == q.tck_s[1]) && !q.tck_s[2] && q.tck_lvl;
        shifting = (tap.state == bst_pkg::ST_SHDR)
                   || (tap.state == bst_pkg::ST_SHIR);
    end

    assign tap.tck_rise = rise;
    assign tap.tms = q.tms_lvl;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.tck_s = {q.tck_s[1:0], tck_in};
        d.tms_s = {q.tms_s[1:0], tms_in};
        d.tdi_s = {q.tdi_s[1:0], tdi_in};
        if (q.tck_s[2] == q.tck_s[1]) begin
            d.tck_lvl = q.tck_s[2];
        end
        if (q.tms_s[2] == q.tms_s[1]) begin
            d.tms_lvl = q.tms_s[2];
        end
        if (q.tdi_s[2] == q.tdi_s[1]) begin
            d.tdi_lvl = q.tdi_s[2];
        end
        if (rise) begin
            unique case (tap.state)
                bst_pkg::ST_CAPIR: d.ir_sh = bst_pkg::IR_CAPTURE;
                bst_pkg::ST_SHIR: d.ir_sh = {q.tdi_lvl, q.ir_sh[2:1]};
                bst_pkg::ST_CAPDR: begin
                    d.dr_sh = {core_oe_in, core_out_in, pin_in_in};
                    d.id_sh = {bst_pkg::ID_VER, bst_pkg::ID_PART,
                               bst_pkg::ID_MFR, bst_pkg::ID_FIXED};
                    d.byp = 1'b0;
                end
                bst_pkg::ST_SHDR: begin
                    if (uses_chain(q.ir)) begin
                        d.dr_sh = {q.tdi_lvl, q.dr_sh[BSW-1:1]};
                    end else if (q.ir == bst_pkg::IR_IDCODE) begin
                        d.id_sh = {q.tdi_lvl, q.id_sh[31:1]};
                    end else begin
                        d.byp = q.tdi_lvl;
                    end
                end
                default: d.byp = q.byp;
            endcase
        end
        if (fall) begin
            d.tdo_oe = shifting;
            if (tap.state == bst_pkg::ST_SHIR) begin
                d.tdo = q.ir_sh[0];
            end else if (tap.state == bst_pkg::ST_SHDR) begin
                if (uses_chain(q.ir)) begin
                    d.tdo = q.dr_sh[0];
                end else if (q.ir == bst_pkg::IR_IDCODE) begin
                    d.tdo = q.id_sh[0];
                end else begin
                    d.tdo = q.byp;
                end
            end
            if (tap.state == bst_pkg::ST_UPIR) begin
                d.ir = q.ir_sh;
            end
            if (tap.state == bst_pkg::ST_UPDR && uses_chain(q.ir)) begin
                d.upd = q.dr_sh;
            end
        end
        if (tap.state == bst_pkg::ST_TLR) begin
            d.ir = bst_pkg::IR_IDCODE;
        end
        // pin muxing
        d.core_in = pin_in_in;
        d.pin_out = core_out_in;
        d.pin_oe = core_oe_in;
        if (drives_chain(q.ir)) begin
            d.pin_out = q.upd[2*NPIN-1:NPIN];
            d.pin_oe = q.upd[BSW-1:2*NPIN];
        end else if (q.ir == bst_pkg::IR_HIGHZ) begin
            d.pin_oe = '0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.ir <= bst_pkg::IR_IDCODE;
        end else if (ce_in) begin
            q <= d;
        end
    end

    assign tdo_out = q.tdo;
    assign tdo_oe_out = q.tdo_oe;
    assign pin_out_out = q.pin_out;
    assign pin_oe_out = q.pin_oe;
    assign core_in_out = q.core_in;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [2:0] hi_cnt;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            hi_cnt <= 3'h0;
        end else if (ce_in && rise) begin
            if (!q.tms_lvl) begin
                hi_cnt <= 3'h0;
            end else if (hi_cnt != 3'(bst_pkg::TLR_RISES)) begin
                hi_cnt <= hi_cnt + 3'h1;
            end
        end
    end

    tlr_forced_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        hi_cnt == 3'(bst_pkg::TLR_RISES) |-> tap.state == bst_pkg::ST_TLR)
        else $error("five high rises did not reach reset");
    ir_reset_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        ce_in && tap.state == bst_pkg::ST_TLR |=> q.ir == bst_pkg::IR_IDCODE)
        else $error("reset state did not load identification code");
    bypass_delay_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        ce_in && rise && tap.state == bst_pkg::ST_SHDR
        && q.ir == bst_pkg::IR_BYPASS |=> q.byp == $past(q.tdi_lvl))
        else $error("bypass bit did not take serial input");
    ir_lsb_first_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        ce_in && rise && tap.state == bst_pkg::ST_SHIR
        |=> q.ir_sh[2] == $past(q.tdi_lvl))
        else $error("instruction shift order wrong");
    id_capture_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        ce_in && rise && tap.state == bst_pkg::ST_CAPDR |=> q.id_sh[0])
        else $error("identification bit zero not one");
    highz_oe_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        ce_in && q.ir == bst_pkg::IR_HIGHZ |=> pin_oe_out == '0)
        else $error("output enabled under high-z");
    clamp_hold_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        (ce_in && q.ir == bst_pkg::IR_CLAMP)[*2] |=> $stable(pin_out_out))
        else $error("pins moved under clamp");
    sample_pass_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        ce_in && q.ir == bst_pkg::IR_SAMPLE
        |=> pin_out_out == $past(core_out_in)
        && core_in_out == $past(pin_in_in))
        else $error("sample disturbed system path");
    tdo_idle_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in)
        ce_in && fall && !shifting |=> !tdo_oe_out)
        else $error("serial output driven outside shift");
endmodule

// [design/bst_pkg.sv]
package bst_pkg;
    // ----------------------------------------
    // instruction codes
    // ----------------------------------------
    localparam int IR_W = 3;
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_SAMPLE = 3'h2;
    localparam logic [2:0] IR_CLAMP = 3'h3;
    localparam logic [2:0] IR_HIGHZ = 3'h4;
    localparam logic [2:0] IR_MFG = 3'h5;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAPTURE = 3'h1;
    // ----------------------------------------
    // identification word layout
    // ----------------------------------------
    localparam int ID_W = 32;
    localparam int MFR_W = 11;
    localparam int PART_W = 16;
    localparam int VER_W = 4;
    // neutral values, arbitrary
    localparam logic [10:0] ID_MFR = 11'h00a;
    localparam logic [15:0] ID_PART = 16'h0001;
    localparam logic [3:0] ID_VER = 4'h1;
    localparam logic ID_FIXED = 1'b1;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int TLR_RISES = 5;
    localparam int SYNC_W = 3;
    // ----------------------------------------
    // port controller states, gray along path
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_TLR = 4'h0,
        ST_RTI = 4'h1,
        ST_SELDR = 4'h3,
        ST_CAPDR = 4'h2,
        ST_SHDR = 4'h6,
        ST_EX1DR = 4'h7,
        ST_PAUSEDR = 4'h5,
        ST_EX2DR = 4'h4,
        ST_UPDR = 4'hc,
        ST_SELIR = 4'hd,
        ST_CAPIR = 4'hf,
        ST_SHIR = 4'he,
        ST_EX1IR = 4'ha,
        ST_PAUSEIR = 4'hb,
        ST_EX2IR = 4'h9,
        ST_UPIR = 4'h8
    } bst_state_t;
endpackage

// [design/bst_tap_if.sv]
`timescale 1ns/10ps
interface bst_tap_if;
    logic tms;
    logic tck_rise;
    bst_pkg::bst_state_t state;
    modport fsm (input tms, input tck_rise, output state);
    modport ctl (output tms, output tck_rise, input state);
endinterface

// [design/bst_fsm.sv]
`timescale 1ns/10ps
module bst_fsm (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    bst_tap_if.fsm tap
);
    typedef struct packed {
        bst_pkg::bst_state_t st;
    } bst_fsm_state_t;

    bst_fsm_state_t q;
    bst_fsm_state_t d;

    function automatic bst_pkg::bst_state_t nxt(
        input bst_pkg::bst_state_t s, input logic m);
        unique case (s)
            bst_pkg::ST_TLR: nxt = m ? bst_pkg::ST_TLR : bst_pkg::ST_RTI;
            bst_pkg::ST_RTI: nxt = m ? bst_pkg::ST_SELDR : bst_pkg::ST_RTI;
            bst_pkg::ST_SELDR: nxt = m ? bst_pkg::ST_SELIR : bst_pkg::ST_CAPDR;
            bst_pkg::ST_CAPDR: nxt = m ? bst_pkg::ST_EX1DR : bst_pkg::ST_SHDR;
            bst_pkg::ST_SHDR: nxt = m ? bst_pkg::ST_EX1DR : bst_pkg::ST_SHDR;
            bst_pkg::ST_EX1DR: nxt = m ? bst_pkg::ST_UPDR : bst_pkg::ST_PAUSEDR;
            bst_pkg::ST_PAUSEDR: nxt = m ? bst_pkg::ST_EX2DR
                                         : bst_pkg::ST_PAUSEDR;
            bst_pkg::ST_EX2DR: nxt = m ? bst_pkg::ST_UPDR : bst_pkg::ST_SHDR;
            bst_pkg::ST_UPDR: nxt = m ? bst_pkg::ST_SELDR : bst_pkg::ST_RTI;
            bst_pkg::ST_SELIR: nxt = m ? bst_pkg::ST_TLR : bst_pkg::ST_CAPIR;
            bst_pkg::ST_CAPIR: nxt = m ? bst_pkg::ST_EX1IR : bst_pkg::ST_SHIR;
            bst_pkg::ST_SHIR: nxt = m ? bst_pkg::ST_EX1IR : bst_pkg::ST_SHIR;
            bst_pkg::ST_EX1IR: nxt = m ? bst_pkg::ST_UPIR : bst_pkg::ST_PAUSEIR;
            bst_pkg::ST_PAUSEIR: nxt = m ? bst_pkg::ST_EX2IR
                                         : bst_pkg::ST_PAUSEIR;
            bst_pkg::ST_EX2IR: nxt = m ? bst_pkg::ST_UPIR : bst_pkg::ST_SHIR;
            bst_pkg::ST_UPIR: nxt = m ? bst_pkg::ST_SELDR : bst_pkg::ST_RTI;
        endcase
    endfunction

    // ----------------------------------------
    // advance only on test clock rise
    // ----------------------------------------
    always_comb begin
        d = q;
        if (tap.tck_rise) begin
            d.st = nxt(q.st, tap.tms);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            q <= '{st: bst_pkg::ST_TLR};
        end else if (ce_in) begin
            q <= d;
        end
    end

    assign tap.state = q.st;
endmodule

// [tb/bst_tester.sv]
`timescale 1ns/10ps
module bst_tester (
    input wire logic clk_sys_in,
    input wire logic tdo_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    // ----------------------------------------
    // test clock cycles, 8 system clocks each
    // ----------------------------------------
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end

    task automatic step(input logic m, input logic d, output logic o);
        tms_out = m;
        tdi_out = d;
        repeat (4) @(negedge clk_sys_in);
        o = tdo_in;
        tck_out = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        tck_out = 1'b0;
    endtask

    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    task automatic reset_tap();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
endmodule

// [tb/boundary_scan_tap_bench.sv]
`timescale 1ns/10ps
module boundary_scan_tap_bench;
    localparam int NPIN = 8;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe, o_bit;
    logic [NPIN-1:0] pin_in, core_out, core_oe, pin_out, pin_oe, core_in;
    logic [31:0] got, din, din2;
    logic [2:0] codes [4] = '{3'h7, 3'h6, 3'h5, 3'h4};
    integer seed = 32'h5be9_2539;
    int err_count = 0;
    int compares = 0;

    bst_tap #(.NPIN(NPIN)) i_bst_tap (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .ce_in(1'b1), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .pin_in_in(pin_in), .core_out_in(core_out),
        .core_oe_in(core_oe), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .pin_out_out(pin_out), .pin_oe_out(pin_oe), .core_in_out(core_in));
    bst_tester i_bst_tester (.clk_sys_in(clk_sys_in), .tdo_in(tdo),
        .tck_out(tck), .tms_out(tms), .tdi_out(tdi));

    always #20 clk_sys_in = ~clk_sys_in;

    // ----------------------------------------
    // expectations and checks
    // ----------------------------------------
    function automatic logic [31:0] id_word();
        return {bst_pkg::ID_VER, bst_pkg::ID_PART, bst_pkg::ID_MFR,
                bst_pkg::ID_FIXED};
    endfunction

    function automatic logic [31:0] byp8(input logic [31:0] d);
        return {24'h0, d[6:0], 1'b0};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] act);
        compares++;
        if (act !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, act);
        end
    endtask

    task automatic results();
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic new_inputs();
        pin_in = NPIN'($random(seed));
        core_out = NPIN'($random(seed));
        core_oe = NPIN'($random(seed));
        repeat (4) @(negedge clk_sys_in);
    endtask

    task automatic load_ir(input logic [2:0] code);
        i_bst_tester.scan(1'b1, 3, {29'h0, code}, got);
        chk("ir capture", 32'h1, got);
        repeat (4) @(negedge clk_sys_in);
    endtask

    task automatic pass_chk();
        chk("pin out", core_out, pin_out);
        chk("pin oe", core_oe, pin_oe);
        chk("core in", pin_in, core_in);
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys_in);
        err_count++;
        results();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        pin_in = '0;
        core_out = '0;
        core_oe = '0;
        repeat (8) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        new_inputs();
        chk("tdo oe idle", 32'h0, tdo_oe);
        pass_chk();
        i_bst_tester.reset_tap();
        i_bst_tester.scan(1'b0, 32, $random(seed), got);
        chk("id word", id_word(), got);
        repeat (4) @(negedge clk_sys_in);
        chk("tdo oe after", 32'h0, tdo_oe);
        foreach (codes[k]) begin
            load_ir(codes[k]);
            new_inputs();
            din = $random(seed);
            i_bst_tester.scan(1'b0, 8, din, got);
            chk("bypass path", byp8(din), got);
            if (codes[k] == 3'h4) chk("highz oe", 32'h0, pin_oe);
            else pass_chk();
        end
        load_ir(3'h2);
        new_inputs();
        pass_chk();
        din = $random(seed);
        i_bst_tester.scan(1'b0, 24, din, got);
        chk("sample cap", {8'h0, core_oe, core_out, pin_in}, got);
        pass_chk();
        load_ir(3'h0);
        chk("preload out", din[15:8], pin_out);
        chk("preload oe", din[23:16], pin_oe);
        new_inputs();
        din2 = $random(seed);
        i_bst_tester.scan(1'b0, 24, din2, got);
        chk("extest cap", pin_in, got[7:0]);
        repeat (4) @(negedge clk_sys_in);
        chk("extest out", din2[15:8], pin_out);
        chk("extest oe", din2[23:16], pin_oe);
        load_ir(3'h3);
        new_inputs();
        din = $random(seed);
        i_bst_tester.scan(1'b0, 8, din, got);
        chk("clamp path", byp8(din), got);
        chk("clamp out", din2[15:8], pin_out);
        chk("clamp oe", din2[23:16], pin_oe);
        i_bst_tester.step(1'b1, 1'b0, o_bit);
        i_bst_tester.step(1'b0, 1'b0, o_bit);
        i_bst_tester.step(1'b0, 1'b0, o_bit);
        i_bst_tester.reset_tap();
        new_inputs();
        pass_chk();
        i_bst_tester.scan(1'b0, 32, $random(seed), got);
        chk("id after reset", id_word(), got);
        results();
    end
endmodule
